/* File: core/input_overvoltage_fault_response.sv */
// Input over-voltage fault response controller with its command registers
`include "ovf_cfg.svh"

// How it works
// - Response 00: output keeps running on fault
// - Response 01: run on for decoded delay
// - Fault still present after delay: apply retries
// - Response 10: disable at once, then retry
// - Response 11: off until cleared or cycled
// - Retry 000: never restart, stay off
// - Retry 001..110: one to six restarts
// - All restarts failed: latch output off
// - Restart spacing equals decoded delay units
// - Retry 111: restart forever until stopped
// - Delay code n means 2^n units
// - Delay unit comes from external timebase
// - Warning threshold is host read/write
// - Action byte lives at its code
// - Fault when input exceeds fault threshold
module input_overvoltage_fault_response #(
   parameter int DELAY_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire ovf_pkg::cmd_t cmd,
   input wire logic [15:0] vin_meas,
   input wire logic output_on_req,
   input wire logic delay_unit_tick,
   input wire logic other_fault_off,
   output logic rsp_valid_reg,
   output logic [15:0] rsp_rdata_reg,
   output logic output_enable_reg,
   output logic fault_flag_reg,
   output logic warn_flag_reg,
   output ovf_pkg::state_t state_reg
);
   // ==========================================
   // Decode helpers
   // Delay code n gives 2^n units
   function automatic logic [DELAY_W-1:0] delay_units(input logic [2:0] code);
      delay_units = DELAY_W'(1) << code;
   endfunction

   function automatic logic is_write(input logic v, input ovf_pkg::cmd_t c, input logic [7:0] k);
      is_write = v && c.write && (c.code == k);
   endfunction

   // ==========================================
   // Registers
   logic [15:0] fault_limit_reg;
   logic [15:0] warn_limit_reg;
   logic [7:0] action_reg;
   logic [DELAY_W-1:0] delay_cnt_reg;
   logic [2:0] attempts_reg;
   logic output_on_d_reg;
   ovf_pkg::state_t state_next;

   ovf_pkg::resp_t resp;
   logic [2:0] retry_set;
   logic [DELAY_W-1:0] delay_target;
   logic fault_now, warn_now, clear_cmd, clear_fault_bit, clear_warn_bit;
   logic delay_done, restart_edge, timed_state;

   assign resp = ovf_pkg::resp_t'(action_reg[`OVF_RESP_HI:`OVF_RESP_LO]);
   assign retry_set = action_reg[`OVF_RETRY_HI:`OVF_RETRY_LO];
   assign delay_target = delay_units(action_reg[`OVF_DELAY_HI:`OVF_DELAY_LO]);
   // Magnitude compare; both values share the same linear exponent
   assign fault_now = vin_meas > fault_limit_reg;
   assign warn_now = vin_meas > warn_limit_reg;
   assign clear_cmd = cmd_valid && !cmd.write && (cmd.code == `OVF_CODE_CLEAR_FAULTS);
   assign clear_fault_bit = is_write(cmd_valid, cmd, `OVF_CODE_STATUS) &&
                            cmd.wdata[`OVF_STAT_FAULT];
   assign clear_warn_bit = is_write(cmd_valid, cmd, `OVF_CODE_STATUS) &&
                           cmd.wdata[`OVF_STAT_WARN];
   assign timed_state = (state_reg == ovf_pkg::ST_DELAY) || (state_reg == ovf_pkg::ST_OFF_WAIT);
   // Time base ticks once per delay unit on the delay_unit_tick input
   assign delay_done = timed_state && delay_unit_tick &&
                       (delay_cnt_reg == delay_target - DELAY_W'(1));
   assign restart_edge = output_on_req && !output_on_d_reg;

   // ==========================================
   // Host writes; writes to unknown codes are dropped
   always_ff @(posedge clk) begin
      if (reset) begin
         fault_limit_reg <= `OVF_RST_FAULT_LIMIT;
         warn_limit_reg <= `OVF_RST_WARN_LIMIT;
         action_reg <= `OVF_RST_ACTION;
      end else begin
         if (is_write(cmd_valid, cmd, `OVF_CODE_FAULT_LIMIT)) begin
            fault_limit_reg <= cmd.wdata;
         end
         if (is_write(cmd_valid, cmd, `OVF_CODE_WARN_LIMIT)) begin
            warn_limit_reg <= cmd.wdata;
         end
         if (is_write(cmd_valid, cmd, `OVF_CODE_FAULT_ACTION)) begin
            action_reg <= cmd.wdata[7:0];
         end
      end
   end

   // Host reads answer one cycle later; unknown codes read zero
   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_valid_reg <= 1'b0;
         rsp_rdata_reg <= `OVF_ZERO16;
      end else begin
         rsp_valid_reg <= cmd_valid && !cmd.write && !clear_cmd;
         if (cmd_valid && !cmd.write) begin
            unique case (cmd.code)
               `OVF_CODE_FAULT_LIMIT: rsp_rdata_reg <= fault_limit_reg;
               `OVF_CODE_WARN_LIMIT: rsp_rdata_reg <= warn_limit_reg;
               `OVF_CODE_FAULT_ACTION: rsp_rdata_reg <= {8'h00, action_reg};
               `OVF_CODE_STATUS: rsp_rdata_reg <= {14'h0000, warn_flag_reg, fault_flag_reg};
               default: rsp_rdata_reg <= `OVF_ZERO16;
            endcase
         end
      end
   end

   // ==========================================
   // Sticky flags; a new event wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         fault_flag_reg <= 1'b0;
         warn_flag_reg <= 1'b0;
      end else begin
         if (state_reg == ovf_pkg::ST_RUN && output_on_req && fault_now) begin
            fault_flag_reg <= 1'b1;
         end else if (clear_cmd || clear_fault_bit) begin
            fault_flag_reg <= 1'b0;
         end
         if (warn_now) begin
            warn_flag_reg <= 1'b1;
         end else if (clear_cmd || clear_warn_bit) begin
            warn_flag_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // Response state machine
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ovf_pkg::ST_RUN: begin
            if (!output_on_req) begin
               state_next = ovf_pkg::ST_CMD_OFF;
            end else if (other_fault_off) begin
               state_next = ovf_pkg::ST_LATCHED;
            end else if (fault_now) begin
               unique case (resp)
                  ovf_pkg::RESP_IGNORE: state_next = ovf_pkg::ST_RUN;
                  ovf_pkg::RESP_RUN_THEN_RETRY: state_next = ovf_pkg::ST_DELAY;
                  ovf_pkg::RESP_OFF_AND_RETRY:
                     state_next = (retry_set == `OVF_RETRY_NONE) ?
                                  ovf_pkg::ST_LATCHED : ovf_pkg::ST_OFF_WAIT;
                  ovf_pkg::RESP_OFF_UNTIL_CLEAR: state_next = ovf_pkg::ST_LATCHED;
               endcase
            end
         end
         ovf_pkg::ST_DELAY: begin
            if (!output_on_req) begin
               state_next = ovf_pkg::ST_CMD_OFF;
            end else if (other_fault_off) begin
               state_next = ovf_pkg::ST_LATCHED;
            end else if (delay_done) begin
               if (!fault_now) begin
                  state_next = ovf_pkg::ST_RUN;
               end else begin
                  state_next = (retry_set == `OVF_RETRY_NONE) ?
                               ovf_pkg::ST_LATCHED : ovf_pkg::ST_OFF_WAIT;
               end
            end
         end
         ovf_pkg::ST_OFF_WAIT: begin
            if (!output_on_req) begin
               state_next = ovf_pkg::ST_CMD_OFF;
            end else if (other_fault_off) begin
               state_next = ovf_pkg::ST_LATCHED;
            end else if (delay_done) begin
               // A restart fails when the fault is still present at its start
               if (!fault_now) begin
                  state_next = ovf_pkg::ST_RUN;
               end else if (retry_set != `OVF_RETRY_FOREVER &&
                            attempts_reg + 3'h1 >= retry_set) begin
                  state_next = ovf_pkg::ST_LATCHED;
               end
            end
         end
         ovf_pkg::ST_LATCHED: begin
            if (!output_on_req) begin
               state_next = ovf_pkg::ST_CMD_OFF;
            end else if (clear_cmd || clear_fault_bit) begin
               state_next = ovf_pkg::ST_RUN;
            end
         end
         ovf_pkg::ST_CMD_OFF: begin
            if (restart_edge) begin
               state_next = ovf_pkg::ST_RUN;
            end
         end
         default: state_next = ovf_pkg::ST_CMD_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= ovf_pkg::ST_CMD_OFF;
         output_on_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         output_on_d_reg <= output_on_req;
      end
   end

   // Output drive follows the next state so a disable lands at once
   always_ff @(posedge clk) begin
      if (reset) begin
         output_enable_reg <= 1'b0;
      end else begin
         output_enable_reg <= (state_next == ovf_pkg::ST_RUN) ||
                              (state_next == ovf_pkg::ST_DELAY);
      end
   end

   // ==========================================
   // Delay unit counter, restarted on entry and at each restart attempt
   always_ff @(posedge clk) begin
      if (reset) begin
         delay_cnt_reg <= '0;
      end else if (state_next != state_reg || delay_done || !timed_state) begin
         delay_cnt_reg <= '0;
      end else if (delay_unit_tick) begin
         delay_cnt_reg <= delay_cnt_reg + DELAY_W'(1);
      end
   end

   // Restart attempts made since the fault was taken
   always_ff @(posedge clk) begin
      if (reset) begin
         attempts_reg <= 3'h0;
      end else if (state_reg != ovf_pkg::ST_OFF_WAIT) begin
         attempts_reg <= 3'h0;
      end else if (delay_done && attempts_reg != 3'h7) begin
         attempts_reg <= attempts_reg + 3'h1;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_ignore_keeps_on: assert property (
      state_reg == ovf_pkg::ST_RUN && output_on_req && !other_fault_off && fault_now &&
      resp == ovf_pkg::RESP_IGNORE |=> output_enable_reg && state_reg == ovf_pkg::ST_RUN)
      else $error("ignored fault dropped the output");
   a_delay_runs_on: assert property (
      state_reg == ovf_pkg::ST_RUN && output_on_req && !other_fault_off && fault_now &&
      resp == ovf_pkg::RESP_RUN_THEN_RETRY |=> output_enable_reg &&
      state_reg == ovf_pkg::ST_DELAY)
      else $error("run-then-retry cut the output early");
   a_persist_retry: assert property (
      state_reg == ovf_pkg::ST_DELAY && output_on_req && !other_fault_off && delay_done &&
      fault_now |=> state_reg inside {ovf_pkg::ST_OFF_WAIT, ovf_pkg::ST_LATCHED})
      else $error("persistent fault not handed to retries");
   a_disable_at_once: assert property (
      state_reg == ovf_pkg::ST_RUN && output_on_req && fault_now &&
      resp == ovf_pkg::RESP_OFF_AND_RETRY |=> !output_enable_reg)
      else $error("disable-and-retry left output on");
   a_latch_holds: assert property (
      state_reg == ovf_pkg::ST_LATCHED && output_on_req && !clear_cmd && !clear_fault_bit
      |=> state_reg == ovf_pkg::ST_LATCHED && !output_enable_reg)
      else $error("latched fault released without a clear");
   a_no_retry_zero: assert property (
      state_reg != ovf_pkg::ST_OFF_WAIT && retry_set == `OVF_RETRY_NONE
      |=> state_reg != ovf_pkg::ST_OFF_WAIT)
      else $error("restart wait entered with retries off");
   a_attempts_bound: assert property (
      state_reg == ovf_pkg::ST_OFF_WAIT && retry_set != `OVF_RETRY_FOREVER
      |-> attempts_reg < retry_set)
      else $error("more restarts than allowed");
   a_exhaust_latch: assert property (
      state_reg == ovf_pkg::ST_OFF_WAIT && output_on_req && !other_fault_off && delay_done &&
      fault_now && retry_set != `OVF_RETRY_FOREVER && attempts_reg + 3'h1 == retry_set
      |=> state_reg == ovf_pkg::ST_LATCHED)
      else $error("exhausted retries did not latch off");
   a_spacing_limit: assert property (
      timed_state |-> delay_cnt_reg < delay_target)
      else $error("delay counter ran past decoded units");
   a_retry_forever: assert property (
      state_reg == ovf_pkg::ST_OFF_WAIT && output_on_req && !other_fault_off && delay_done &&
      fault_now && retry_set == `OVF_RETRY_FOREVER |=> state_reg == ovf_pkg::ST_OFF_WAIT)
      else $error("continuous retry stopped");
   a_warn_write: assert property (
      is_write(cmd_valid, cmd, `OVF_CODE_WARN_LIMIT) |=> warn_limit_reg == $past(cmd.wdata))
      else $error("warning threshold write lost");
   a_warn_flag: assert property (
      warn_now |=> warn_flag_reg)
      else $error("warning flag not raised");

   c_exhaust: cover property (state_reg == ovf_pkg::ST_OFF_WAIT ##1
      state_reg == ovf_pkg::ST_LATCHED);
   c_restart_ok: cover property (state_reg == ovf_pkg::ST_OFF_WAIT ##1
      state_reg == ovf_pkg::ST_RUN);
   c_latch_clear: cover property (state_reg == ovf_pkg::ST_LATCHED ##1
      state_reg == ovf_pkg::ST_RUN);
endmodule

/* File: core/ovf_cfg.svh */
// Command codes, field positions and reset values of the over-voltage fault responder
`ifndef OVF_CFG_SVH
`define OVF_CFG_SVH
// ==========================================
// Command codes
`define OVF_CODE_FAULT_LIMIT 8'h55
`define OVF_CODE_FAULT_ACTION 8'h56
`define OVF_CODE_WARN_LIMIT 8'h57
`define OVF_CODE_CLEAR_FAULTS 8'h03
`define OVF_CODE_STATUS 8'h7c
// ==========================================
// Field positions of the action byte
`define OVF_RESP_HI 7
`define OVF_RESP_LO 6
`define OVF_RETRY_HI 5
`define OVF_RETRY_LO 3
`define OVF_DELAY_HI 2
`define OVF_DELAY_LO 0
// Status bits, write one to clear
`define OVF_STAT_FAULT 0
`define OVF_STAT_WARN 1
// ==========================================
// Codes and reset values
`define OVF_RETRY_NONE 3'h0
`define OVF_RETRY_FOREVER 3'h7
`define OVF_RST_FAULT_LIMIT 16'hffff
`define OVF_RST_WARN_LIMIT 16'hffff
`define OVF_RST_ACTION 8'hc0
`define OVF_ZERO16 16'h0000
`endif

/* File: core/ovf_pkg.sv */
// Types shared by the over-voltage fault responder
package ovf_pkg;
   // ==========================================
   // Reaction selected by the action byte
   typedef enum logic [1:0] {
      RESP_IGNORE = 2'b00,
      RESP_RUN_THEN_RETRY = 2'b01,
      RESP_OFF_AND_RETRY = 2'b10,
      RESP_OFF_UNTIL_CLEAR = 2'b11
   } resp_t;
   // Controller states
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_DELAY = 3'b001,
      ST_OFF_WAIT = 3'b010,
      ST_LATCHED = 3'b011,
      ST_CMD_OFF = 3'b100
   } state_t;
   // One host command
   typedef struct packed {
      logic write;
      logic [7:0] code;
      logic [15:0] wdata;
   } cmd_t;
endpackage

/* File: sim/host_model.sv */
// Management-bus host model that issues commands to the fault responder
module host_model (
   input wire logic clk,
   input wire logic rsp_valid_reg,
   input wire logic [15:0] rsp_rdata_reg,
   output logic cmd_valid,
   output ovf_pkg::cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Command port driver
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // One command, held for exactly the edge that takes it
   task automatic send(input logic wr, input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{write: wr, code: c, wdata: d};
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd <= '{write: ~wr, code: ~c, wdata: ~d}; // Idle bus shows junk, not the last word
   endtask
   // Answer is looked at one edge after the request, where it stands
   task automatic read(input logic [7:0] c, output logic [15:0] rd, output logic ok);
      send(1'b0, c, 16'h0000);
      #1;
      ok = rsp_valid_reg;
      rd = rsp_rdata_reg;
   endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the input over-voltage fault responder
`include "ovf_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] VHI = 16'h0400;
   localparam logic [15:0] VLO = 16'h0100;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] vin_meas = 16'h0100;
   logic output_on_req = 1'b0;
   logic delay_unit_tick = 1'b0;
   logic other_fault_off = 1'b0;
   logic cmd_valid;
   ovf_pkg::cmd_t cmd;
   logic rsp_valid_reg;
   logic [15:0] rsp_rdata_reg;
   logic output_enable_reg;
   logic fault_flag_reg;
   logic warn_flag_reg;
   ovf_pkg::state_t state_reg;
   int failures = 0;
   int samples_checked = 0;
   // ==========================================
   // Clock, design and host
   always #50 clk = ~clk;
   input_overvoltage_fault_response #(.DELAY_W(8)) dut (
      .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .vin_meas(vin_meas),
      .output_on_req(output_on_req), .delay_unit_tick(delay_unit_tick),
      .other_fault_off(other_fault_off), .rsp_valid_reg(rsp_valid_reg),
      .rsp_rdata_reg(rsp_rdata_reg), .output_enable_reg(output_enable_reg),
      .fault_flag_reg(fault_flag_reg), .warn_flag_reg(warn_flag_reg), .state_reg(state_reg));
   host_model host (
      .clk(clk), .rsp_valid_reg(rsp_valid_reg), .rsp_rdata_reg(rsp_rdata_reg),
      .cmd_valid(cmd_valid), .cmd(cmd));
   // ==========================================
   // Shared helpers
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      host.read(c, d, ok);
      check("rsp_valid", {15'h0, ok}, 16'h0001);
      check("rdata", d, exp);
      // The answer strobe stands for one cycle only
      cyc(1);
      check("rsp_valid_end", 16'(rsp_valid_reg), 16'h0000);
   endtask
   task automatic act(input logic [7:0] a);
      host.send(1'b1, `OVF_CODE_FAULT_ACTION, {8'h00, a});
   endtask
   // Input jumps over the fault limit; the state moves at the next edge
   task automatic trip();
      @(posedge clk) vin_meas <= VHI;
      cyc(1);
   endtask
   task automatic tick();
      @(posedge clk) delay_unit_tick <= 1'b1;
      @(posedge clk) delay_unit_tick <= 1'b0;
      #1;
   endtask
   // Counts delay units until the output is latched off, bounded by lim
   task automatic ticks_to_latch(input int lim, output int n);
      n = 0;
      while (state_reg !== ovf_pkg::ST_LATCHED && n < lim) begin
         tick();
         n++;
      end
   endtask
   task automatic recover();
      @(posedge clk) vin_meas <= VLO;
      host.send(1'b0, `OVF_CODE_CLEAR_FAULTS, 16'h0000);
      cyc(2);
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_RUN));
      check("out_en", 16'(output_enable_reg), 16'h0001);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs();
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_CMD_OFF));
      rd_chk(`OVF_CODE_WARN_LIMIT, `OVF_RST_WARN_LIMIT);
      rd_chk(`OVF_CODE_FAULT_ACTION, 16'h00c0);
      host.send(1'b1, `OVF_CODE_WARN_LIMIT, 16'ha55a);
      rd_chk(`OVF_CODE_WARN_LIMIT, 16'ha55a);
      rd_chk(8'h99, 16'h0000);
      host.send(1'b1, `OVF_CODE_FAULT_LIMIT, 16'h0300);
      rd_chk(`OVF_CODE_FAULT_LIMIT, 16'h0300);
      @(posedge clk) output_on_req <= 1'b1;
      cyc(2);
      check("out_en", 16'(output_enable_reg), 16'h0001);
   endtask
   task automatic t_warn();
      host.send(1'b1, `OVF_CODE_WARN_LIMIT, 16'h0200);
      @(posedge clk) vin_meas <= 16'h0300; // Equal to fault limit: not above it
      cyc(2);
      check("warn", 16'(warn_flag_reg), 16'h0001);
      check("fault", 16'(fault_flag_reg), 16'h0000);
      check("out_en", 16'(output_enable_reg), 16'h0001);
      @(posedge clk) vin_meas <= VLO;
      host.send(1'b1, `OVF_CODE_STATUS, 16'h0002);
      cyc(1);
      check("warn", 16'(warn_flag_reg), 16'h0000);
   endtask
   task automatic t_ignore();
      act(8'h00);
      trip();
      cyc(10);
      check("out_en", 16'(output_enable_reg), 16'h0001);
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_RUN));
      recover();
   endtask
   task automatic t_run_on();
      act(8'h42);
      rd_chk(`OVF_CODE_FAULT_ACTION, 16'h0042);
      trip();
      repeat (3) tick();
      check("out_en", 16'(output_enable_reg), 16'h0001);
      tick();
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_LATCHED));
      cyc(20);
      check("out_en", 16'(output_enable_reg), 16'h0000);
      recover();
   endtask
   task automatic t_codes();
      int k;
      for (int n = 0; n < 8; n++) begin
         act({5'b10001, 3'(n)});
         trip();
         check("out_en", 16'(output_enable_reg), 16'h0000);
         ticks_to_latch(300, k);
         check("delay_units", 16'(k), 16'(1 << n));
         recover();
      end
   endtask
   task automatic t_retries();
      int k;
      for (int r = 1; r < 7; r++) begin
         act({2'b10, 3'(r), 3'b001});
         trip();
         ticks_to_latch(100, k);
         check("retry_units", 16'(k), 16'(2 * r));
         check("out_en", 16'(output_enable_reg), 16'h0000);
         recover();
      end
      act(8'h99);
      trip();
      @(posedge clk) vin_meas <= VLO;
      repeat (2) tick();
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_RUN));
   endtask
   task automatic t_forever();
      int k;
      act(8'hb8);
      trip();
      ticks_to_latch(200, k);
      check("forever_units", 16'(k), 16'h00c8);
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_OFF_WAIT));
      @(posedge clk) other_fault_off <= 1'b1;
      cyc(2);
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_LATCHED));
      @(posedge clk) other_fault_off <= 1'b0;
      recover();
   endtask
   task automatic t_latch();
      act(8'hc0);
      trip();
      @(posedge clk) vin_meas <= VLO;
      cyc(5);
      check("out_en", 16'(output_enable_reg), 16'h0000);
      check("fault", 16'(fault_flag_reg), 16'h0001);
      rd_chk(`OVF_CODE_STATUS, 16'h0003);
      host.send(1'b1, `OVF_CODE_STATUS, 16'h0001);
      cyc(2);
      check("out_en", 16'(output_enable_reg), 16'h0001);
      // Bit clear drops only the fault flag; warning stays sticky
      rd_chk(`OVF_CODE_STATUS, 16'h0002);
      trip();
      @(posedge clk) vin_meas <= VLO;
      @(posedge clk) output_on_req <= 1'b0;
      cyc(2);
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_CMD_OFF));
      @(posedge clk) output_on_req <= 1'b1;
      cyc(2);
      check("out_en", 16'(output_enable_reg), 16'h0001);
   endtask
   // Mid-run reset releases a latched fault and restores reset values
   task automatic t_reset();
      trip();
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_LATCHED));
      @(posedge clk) vin_meas <= VLO;
      @(posedge clk) reset <= 1'b1;
      cyc(3);
      check("state", 16'(state_reg), 16'(ovf_pkg::ST_CMD_OFF));
      check("out_en", 16'(output_enable_reg), 16'h0000);
      @(posedge clk) reset <= 1'b0;
      cyc(2);
      check("out_en", 16'(output_enable_reg), 16'h0001);
      check("fault", 16'(fault_flag_reg), 16'h0000);
      rd_chk(`OVF_CODE_FAULT_LIMIT, `OVF_RST_FAULT_LIMIT);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence after a 20-cycle reset
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      cyc(1);
      t_regs();
      t_warn();
      t_ignore();
      t_run_on();
      t_codes();
      t_retries();
      t_forever();
      t_latch();
      t_reset();
      end_sim();
   end
   // Watchdog well beyond the 1300 or so cycles the tests need
   initial begin
      #(100 * 20000);
      failures++;
      end_sim();
   end
endmodule
